// ===== hw/burst_sram.v
// late-write pipelined burst memory core with read data fifo
`include "burst_sram_regs.vh"
module burst_sram #(
  parameter AW     = `SRAM_ADDR_W,
  parameter WORDS  = `SRAM_WORDS,
  parameter LANES  = `SRAM_LANES,
  parameter LANE_W = `SRAM_LANE_W,
  parameter FDEPTH = `SRAM_FIFO_DEPTH
) (
  clk,
  rst,
  clock_hold_n,
  burst_step_load,
  read_write_n,
  chip_select_low_a,
  chip_select_high_b,
  chip_select_low_c,
  addr,
  lane_write_mask,
  burst_order_select,
  out_enable_n,
  snooze_request,
  data_in,
  data_out,
  data_oe,
  rd_valid,
  rd_ready,
  rd_data,
  stall
);
  localparam DW = LANES * LANE_W;
  input  wire             clk;
  input  wire             rst;
  input  wire             clock_hold_n;
  input  wire             burst_step_load;
  input  wire             read_write_n;
  input  wire             chip_select_low_a;
  input  wire             chip_select_high_b;
  input  wire             chip_select_low_c;
  input  wire [AW-1:0]    addr;
  input  wire [LANES-1:0] lane_write_mask;
  input  wire             burst_order_select;
  input  wire             out_enable_n;
  input  wire             snooze_request;
  input  wire [DW-1:0]    data_in;
  output reg  [DW-1:0]    data_out;
  output reg              data_oe;
  output reg              rd_valid;
  input  wire             rd_ready;
  output reg  [DW-1:0]    rd_data;
  output reg              stall;

  //////////////////////////////////////////////////////////////////////////
  reg [DW-1:0] mem [0:WORDS-1];
  reg [AW-1:0]    base_q;
  reg [1:0]       cnt_q;
  reg             bwrite_q;
  reg             bact_q;
  reg [1:0]       v_q;
  reg [1:0]       w_q;
  reg [AW-1:0]    a0_q;
  reg [AW-1:0]    a1_q;
  reg [LANES-1:0] m0_q;
  reg [LANES-1:0] m1_q;
  reg [DW-1:0]    rdpipe_q;
  reg             drive_q;
  wire [AW-1:0]   step_addr;
  wire            adv;
  wire            sel;
  wire            load;
  wire            op_valid;
  wire            op_write;
  wire [AW-1:0]   op_addr;
  wire            f_in_ready;
  wire            f_out_valid;
  wire [DW-1:0]   f_out_data;
  wire            fifo_push;
  wire            f_pop;
  reg  [4:0]      occ_q;

  function [DW-1:0] lane_merge;
    input [DW-1:0]    old_w;
    input [DW-1:0]    new_w;
    input [LANES-1:0] mask_n;
    integer i;
    begin
      lane_merge = old_w;
      for (i = 0; i < LANES; i = i + 1)
        if (!mask_n[i])
          lane_merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // a full fifo holds the whole core like clock hold, so no read is dropped;
  // stall is predicted a cycle ahead so the pin and the freeze agree
  assign adv  = clock_hold_n == 1'b0 && !snooze_request && !stall;
  assign sel  = !chip_select_low_a && chip_select_high_b && !chip_select_low_c;
  assign load = !burst_step_load;
  // a step ignores address, selects and write select
  assign op_valid = load ? sel : bact_q;
  assign op_write = load ? !read_write_n : bwrite_q;
  assign op_addr  = load ? addr : step_addr;

  burst_addr_step #(
    .AW (AW)
  ) u_step (
    .addr_in     (base_q),
    .start_low   (base_q[1:0]),
    .count       (cnt_q + 2'b01),
    .interleaved (burst_order_select == `ORDER_INTERLEAVED),
    .addr_out    (step_addr)
  );

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rst)
    begin
      base_q   <= {AW{1'b0}};
      cnt_q    <= 2'b00;
      bwrite_q <= 1'b0;
      bact_q   <= 1'b0;
      v_q      <= 2'b00;
      w_q      <= 2'b00;
      a0_q     <= {AW{1'b0}};
      a1_q     <= {AW{1'b0}};
      m0_q     <= {LANES{1'b1}};
      m1_q     <= {LANES{1'b1}};
      rdpipe_q <= {DW{1'b0}};
    end
    else if (adv)
    begin
      if (load)
      begin
        base_q   <= addr;
        cnt_q    <= 2'b00;
        bwrite_q <= !read_write_n;
        bact_q   <= sel;
      end
      else
        cnt_q <= cnt_q + 2'b01;
      // two stage pipe keeps write and read latency equal, so no dead cycle
      v_q  <= {v_q[0], op_valid};
      w_q  <= {w_q[0], op_write};
      a0_q <= op_addr;
      a1_q <= a0_q;
      m0_q <= lane_write_mask;
      m1_q <= m0_q;
      if (v_q[0] && !w_q[0])
        rdpipe_q <= mem[a0_q];
      if (v_q[1] && w_q[1])
        mem[a1_q] <= lane_merge(mem[a1_q], data_in, m1_q);
    end
  end

  assign fifo_push = adv && v_q[1] && !w_q[1];
  assign f_pop     = f_out_valid && (!rd_valid || rd_ready);

  //////////////////////////////////////////////////////////////////////////
  // outputs registered; enable follows out_enable_n each cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      drive_q  <= 1'b0;
      data_oe  <= 1'b0;
      data_out <= {DW{1'b0}};
      stall    <= 1'b0;
      occ_q    <= 5'h00;
    end
    else
    begin
      if (adv)
      begin
        drive_q <= v_q[0] && !w_q[0];
        if (v_q[0] && !w_q[0])
          data_out <= mem[a0_q];
      end
      // enable gated by out enable and snooze, not by pipe advance
      data_oe <= (adv ? (v_q[0] && !w_q[0]) : drive_q) && !out_enable_n
                 && !snooze_request;
      if (fifo_push && f_in_ready && !f_pop)
      begin
        occ_q <= occ_q + 5'h01;
        stall <= (occ_q == FDEPTH - 1);
      end
      else if (f_pop && !(fifo_push && f_in_ready))
      begin
        occ_q <= occ_q - 5'h01;
        stall <= 1'b0;
      end
    end
  end

  read_data_fifo #(
    .W     (DW),
    .DEPTH (FDEPTH),
    .PW    (4)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (f_in_ready),
    .in_data   (rdpipe_q),
    .out_valid (f_out_valid),
    .out_ready (!rd_valid || rd_ready),
    .out_data  (f_out_data)
  );

  always @(posedge clk)
  begin
    if (rst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= {DW{1'b0}};
    end
    else if (!rd_valid || rd_ready)
    begin
      rd_valid <= f_out_valid;
      rd_data  <= f_out_data;
    end
  end
endmodule

// ===== include/burst_sram_regs.vh
// constants for the late-write pipelined burst memory
// Behaviour
// - holds 524288 words of 36 bits
// - write data taken two edges after command
// - read data returned one cycle after command
// - reads and writes mix without idle cycles
// - only masked-in byte lanes are written
// - write select, masks, address registered at command
// - any chip select off floats the outputs
// - pipeline finishes two cycles after deselect
// - step input ignores address, selects, write select
// - interleaved and linear burst order supported
// - clock hold freezes every operation
// - output enable gates drivers at the next clock, even in hold
// - standby state entered through a request input
// - interleaved xors low bits, linear counts mod 4
// - order select high interleaved, low linear
// - selected only with selects low, high, low
// - snooze ignores inputs and floats outputs
`ifndef BURST_SRAM_REGS_VH
`define BURST_SRAM_REGS_VH
`define SRAM_WORDS      524288
`define SRAM_ADDR_W     19
`define SRAM_LANES      4
`define SRAM_LANE_W     9
`define SRAM_PIPE_DEPTH 2
`define SRAM_FIFO_DEPTH 16
`define ORDER_INTERLEAVED 1'b1
`endif

// ===== hw/burst_addr_step.v
// next burst address for interleaved or linear order
module burst_addr_step #(
  parameter AW = 19
) (
  addr_in,
  start_low,
  count,
  interleaved,
  addr_out
);
  input  wire [AW-1:0] addr_in;
  input  wire [1:0]    start_low;
  input  wire [1:0]    count;
  input  wire          interleaved;
  output reg  [AW-1:0] addr_out;

  always @*
  begin
    addr_out = addr_in;
    if (interleaved)
      addr_out[1:0] = start_low ^ count;
    else
      addr_out[1:0] = start_low + count;
  end
endmodule

// ===== hw/read_data_fifo.v
// read data fifo with valid/ready on both sides
module read_data_fifo #(
  parameter W     = 36,
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  clk,
  rst,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire         clk;
  input  wire         rst;
  input  wire         in_valid;
  output wire         in_ready;
  input  wire [W-1:0] in_data;
  output wire         out_valid;
  input  wire         out_ready;
  output wire [W-1:0] out_data;

  reg [W-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wr_q;
  reg [PW-1:0] rd_q;
  reg [PW:0]   cnt_q;
  wire push;
  wire pop;

  assign in_ready  = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data  = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
    if (rst)
    begin
      wr_q  <= {PW{1'b0}};
      rd_q  <= {PW{1'b0}};
      cnt_q <= {(PW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ===== tb/wdata_pipe.sv
// controller side write data pipe
module wdata_pipe (
  input  logic        clk,
  input  logic        adv,
  input  logic [35:0] wd,
  output logic [35:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] p_q = 36'h0;
  initial data_in = 36'h0;
  // held or stalled edges do not count toward the two
  always @(posedge clk)
    if (adv)
    begin
      p_q     <= wd;
      data_in <= p_q;
    end
endmodule

// ===== tb/burst_sram_chk_sva.sv
// port checks for the burst memory
module burst_sram_chk (
  input wire        clk,
  input wire        rst,
  input wire        clock_hold_n,
  input wire        burst_step_load,
  input wire        read_write_n,
  input wire        chip_select_low_a,
  input wire        chip_select_high_b,
  input wire        chip_select_low_c,
  input wire        out_enable_n,
  input wire        snooze_request,
  input wire [35:0] data_out,
  input wire        data_oe,
  input wire        stall
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire adv = !clock_hold_n && !snooze_request && !stall;
  wire ld  = adv && !burst_step_load;
  wire sel = !chip_select_low_a && chip_select_high_b && !chip_select_low_c;
  wire rd  = ld && sel && read_write_n;
  wire ds  = ld && !sel;
  wire on  = adv && !out_enable_n;
  a_read_late: assert property ((rd && !out_enable_n) ##1 on |=> data_oe)
    else $error("late read");
  a_write_quiet: assert property (ds ##1 (ld && sel && !read_write_n) ##1 adv |=> !data_oe)
    else $error("driven in write slot");
  a_desel_float: assert property (ds ##1 ds ##1 ds |=> !data_oe)
    else $error("driven when off");
  a_oe_off: assert property (out_enable_n |=> !data_oe)
    else $error("driven, enable off");
  a_snooze_float: assert property (snooze_request |=> !data_oe)
    else $error("driven in snooze");
  a_hold_freeze: assert property (clock_hold_n |=> $stable(data_out))
    else $error("moved in hold");
  a_stall_freeze: assert property (stall |=> $stable(data_out))
    else $error("moved in stall");
  a_burst_read: assert property (rd ##1 (adv && burst_step_load) ##1 on |=> data_oe)
    else $error("burst read lost");
endmodule

bind burst_sram burst_sram_chk chk (.clk, .rst, .clock_hold_n, .burst_step_load, .read_write_n,
  .chip_select_low_a, .chip_select_high_b, .chip_select_low_c, .out_enable_n,
  .snooze_request, .data_out, .data_oe, .stall);

// ===== tb/testbench.sv
// directed bench for the burst memory
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value %0t got %h", $time, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] RD = 4'ha, WR = 4'h2, X1 = 4'he, X2 = 4'h8, X3 = 4'hb;
  logic        clk = 1'b0, rst = 1'b1, hn = 1'b0, st = 1'b0, rw = 1'b1, ord = 1'b1;
  logic        ca = 1'b1, cb = 1'b0, cc = 1'b1, snz = 1'b0, rdy = 1'b1, doe, rv, stall;
  logic        oen = 1'b0;
  logic [3:0]  mask = 4'h0;
  logic [18:0] addr = 19'h0;
  logic [35:0] wd = 36'h0, din, dout, rdat, d;
  int          n_errors = 0, checks = 0;
  wire         adv = !hn && !snz && !stall;
  initial forever #25 clk = ~clk;
  burst_sram dut (.clk, .rst, .clock_hold_n(hn), .burst_step_load(st), .read_write_n(rw),
    .chip_select_low_a(ca), .chip_select_high_b(cb), .chip_select_low_c(cc), .addr,
    .lane_write_mask(mask), .burst_order_select(ord), .out_enable_n(oen),
    .snooze_request(snz), .data_in(din), .data_out(dout), .data_oe(doe), .rd_valid(rv),
    .rd_ready(rdy), .rd_data(rdat), .stall);
  wdata_pipe ctl (.clk, .adv, .wd, .data_in(din));
  task finish_test();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // k is {read_write_n, three selects}; v is the data for two taken edges later
  task cyc(input logic s, input logic [3:0] k, input logic [18:0] a, input logic [35:0] v);
    @(posedge clk);
    st <= s;
    {rw, ca, cb, cc} <= k;
    addr <= a;
    wd <= v;
  endtask
  task at();
    @(posedge clk);
    #1;
  endtask
  task t_mix();
    cyc(1'b0, WR, 19'h10, 36'h111111111);
    cyc(1'b0, WR, 19'h11, 36'h222222222);
    cyc(1'b0, WR, 19'h10, 36'h9abcdef01);
    mask <= 4'ha;
    cyc(1'b0, X1, 19'h10, 36'h0);
    mask <= 4'h0;
    cyc(1'b0, X2, 19'h11, 36'h0);
    cyc(1'b0, RD, 19'h10, 36'h0);
    cyc(1'b0, WR, 19'h12, 36'h333333333);
    cyc(1'b0, RD, 19'h11, 36'h0);
    cyc(1'b0, X3, 19'h0, 36'h0);
    #1;
    d = (36'h111111111 & 36'hff803fe00) | (36'h9abcdef01 & 36'h007fc01ff);
    `CHK(dout, d)
    `CHK(doe, 1'b0)
    at();
    `CHK(dout, 36'h222222222)
    `CHK(doe, 1'b1)
    at();
    `CHK(doe, 1'b0)
  endtask
  // step cycles carry junk selects and address that must be ignored
  task t_burst();
    for (int i = 0; i < 4; i++)
      cyc(i != 0, i != 0 ? RD : WR, i != 0 ? 19'h7ffff : 19'h5, 36'hc00 + 36'(i));
    cyc(1'b0, X1, 19'h0, 36'h0);
    cyc(1'b0, X1, 19'h0, 36'h0);
    ord <= 1'b0;
    // data of command i stands one edge after it; the last two slots deselect
    for (int i = 0; i < 6; i++)
    begin
      cyc(i != 0 && i < 4, i != 0 ? X2 : RD, 19'h6, 36'h0);
      if (i >= 2)
      begin
        #1;
        `CHK(dout, 36'hc05 - 36'(i))
      end
    end
    cyc(1'b0, X1, 19'h0, 36'h0);
  endtask
  task t_hold();
    cyc(1'b0, WR, 19'h8, 36'h5a5a5a5a5);
    cyc(1'b0, X2, 19'h0, 36'h0);
    hn <= 1'b1;
    repeat (2) @(posedge clk);
    hn <= 1'b0;
    repeat (3) @(posedge clk);
    snz <= 1'b1;
    at();
    `CHK(doe, 1'b0)
    @(posedge clk);
    snz <= 1'b0;
    cyc(1'b0, RD, 19'h8, 36'h0);
    cyc(1'b0, X2, 19'h0, 36'h0);
    at();
    at();
    `CHK(dout, 36'h5a5a5a5a5)
    @(posedge clk);
    oen <= 1'b1;
    at();
    `CHK(doe, 1'b0)
    @(posedge clk);
    oen <= 1'b0;
  endtask
  task t_fifo();
    rdy <= 1'b0;
    cyc(1'b0, RD, 19'h0, 36'h0);
    cyc(1'b1, X1, 19'h0, 36'h0);
    for (int i = 0; i < 40 && stall !== 1'b1; i++)
      at();
    `CHK(stall, 1'b1)
    cyc(1'b0, X1, 19'h0, 36'h0);
    rdy <= 1'b1;
    for (int i = 0; i < 40 && rv !== 1'b0; i++)
      at();
    `CHK(rv, 1'b0)
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_mix();
    t_burst();
    t_hold();
    t_fifo();
    finish_test();
  end
  // the sequence needs about a hundred cycles; this is ample
  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule
